//--- rtl/pwmsd_edge_delay.sv
/*
 * holds back each rising edge of one pwm line by a count of steps.
 * assumes the raw line is on mclk; falling edges pass at once.
 */
`timescale 1ns/100ps
module pwmsd_edge_delay
    import pwmsd_pkg::*;
#(
    parameter int W = DELAY_W
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         rawIn,
    input  wire logic [W-1:0] delayCount,
    output logic              delayedOut
);
    localparam int CNT_W = W + 3;
    logic             rawPrev_q;   // last raw level
    logic [CNT_W-1:0] wait_q;      // cycles left before edge goes out

    // count down from the scheduled edge; low cancels any pending edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rawPrev_q  <= 1'b0;
            wait_q     <= '0;
            delayedOut <= 1'b0;
        end else begin
            rawPrev_q <= rawIn;
            if (!rawIn) begin
                wait_q     <= '0;
                delayedOut <= 1'b0;
            end else if (!rawPrev_q) begin
                // delay of zero still costs the output register stage
                wait_q     <= CNT_W'(int'(delayCount) * STEP_CYCLES);
                delayedOut <= (delayCount == '0);
            end else if (wait_q > CNT_W'(1)) begin
                wait_q <= wait_q - CNT_W'(1);
            end else begin
                wait_q     <= '0;
                delayedOut <= 1'b1;
            end
        end
    end

    a_edge_held: assert property (@(posedge mclk) disable iff (rst)
        $rose(rawIn) && delayCount == W'(1) ##4 rawIn
        |-> !delayedOut)
        else $error("active edge went out early");
endmodule : pwmsd_edge_delay

//--- rtl/pwmsd_pkg.sv
/*
 * constants, register layout and carrier types for the pwm shutdown and
 * auto-restart block with active edge delay.
 * assumes one clock (mclk, 40 MHz) and an avalon-mm slave of 32-bit words.
 */
package pwmsd_pkg;
    // word byte addresses on the register bus; five bits so that the
    // clear register at 0x10 does not alias the restart register at 0x0
    localparam logic [4:0] ADDR_RESTART_DELAY = 5'h00;
    localparam logic [4:0] ADDR_SHUTDOWN_CTRL = 5'h04;
    localparam logic [4:0] ADDR_IRQ_STATUS    = 5'h08;
    localparam logic [4:0] ADDR_IRQ_ENABLE    = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_CLEAR     = 5'h10;
    // field positions
    localparam int RESTART_BIT   = 7;
    localparam int FLAG_BIT      = 7;
    localparam int SRC_LSB       = 4;
    localparam int PAIR_AC_LSB   = 2;
    localparam int PAIR_BD_LSB   = 0;
    // reset values
    localparam logic [7:0] RESTART_DELAY_RST = 8'h00;
    localparam logic [7:0] SHUTDOWN_CTRL_RST = 8'h00;
    localparam logic [1:0] IRQ_RST           = 2'h0;
    // one delay count step is one instruction cycle, four oscillator periods
    localparam int TOSC_NS       = 25;
    localparam int STEP_NS       = 4 * TOSC_NS;
    localparam int CLK_NS        = 25;
    localparam int STEP_CYCLES   = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DELAY_W       = 7;
    // interrupt status bits
    localparam int IRQ_ENTER     = 0;
    localparam int IRQ_LEAVE     = 1;

    // pin pair shutdown states
    typedef enum logic [1:0] {
        PAIR_LOW  = 2'b00,
        PAIR_HIGH = 2'b01,
        PAIR_HIZ  = 2'b10
    } pwmsd_pair_e;

    // shutdown control register layout
    typedef struct packed {
        logic       flag;     // shutdown_event_flag
        logic [2:0] src;      // shutdown_source_select
        logic [1:0] pairAc;   // pair_ac_shutdown_state
        logic [1:0] pairBd;   // pair_bd_shutdown_state
    } pwmsd_sdctl_s;

    // four pwm pins as output value plus output enable
    typedef struct packed {
        logic [3:0] value;    // d c b a
        logic [3:0] oe;       // high while driven
    } pwmsd_pins_s;
endpackage : pwmsd_pkg

//--- rtl/pwmsd_top.sv
/*
 * pwm auto-shutdown with firmware or automatic restart and edge delay.
 * assumes pwm raw lines, period start strobe and comparator levels come
 * from mclk logic; the external interrupt pin is asynchronous.
 */
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module pwmsd_top
    import pwmsd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // pwm generator side
    input  wire logic [3:0]  pwmRaw,
    input  wire logic        periodStart,
    input  wire logic        cmpOneHigh,
    input  wire logic        cmpTwoHigh,
    input  wire logic        extIntPin_n,
    // pins and interrupt
    output pwmsd_pins_s      pwmPins,
    output logic             irq
);
    logic [7:0]   restartDelay_q;  // pwm_restart_delay_control
    pwmsd_sdctl_s sdCtl_q;         // pwm_shutdown_control
    logic [1:0]   irqStatus_q;     // sticky enter and leave events
    logic [1:0]   irqEnable_q;     // interrupt mask
    logic         answered_q;      // one wait state then answer
    logic         running_q;       // pwm output live
    logic [1:0]   extSync_q;       // pin synchroniser
    logic         condPrev_q;      // flag last cycle
    logic         restartAuto;     // restart_auto_enable
    logic [DELAY_W-1:0] delayCnt;  // active_edge_delay_count
    logic         extLow;          // pin held low, synchronised
    logic         condition;       // live shutdown condition
    logic         wrAccept;        // write takes effect this edge
    logic         rdAccept;        // read answered this edge
    logic         flagWrite;       // software writes the flag bit
    logic [3:0]   delayed;         // pwm lines after edge delay
    logic [1:0]   irqEvent;        // events raised this cycle

    assign restartAuto = restartDelay_q[RESTART_BIT];
    assign delayCnt    = restartDelay_q[DELAY_W-1:0];

    // bus: every access waits one cycle, then answers
    assign avs_waitrequest = (avs_read | avs_write) & ~answered_q;
    assign wrAccept = avs_write & answered_q;
    assign rdAccept = avs_read & answered_q;
    assign flagWrite = wrAccept && avs_address == ADDR_SHUTDOWN_CTRL
                       && avs_byteenable[0];

    // answered flag drops after each completed access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            answered_q <= 1'b0;
        end else begin
            answered_q <= (avs_read | avs_write) & ~answered_q;
        end
    end

    // two flops before the pin is seen by any logic
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            extSync_q <= 2'b11;
        end else begin
            extSync_q <= {extSync_q[0], extIntPin_n};
        end
    end
    assign extLow = ~extSync_q[1];

    // trigger selection; bit 2 adds the low pin to comparator choices
    always_comb begin
        condition = (sdCtl_q.src[0] & cmpOneHigh)
                  | (sdCtl_q.src[1] & cmpTwoHigh)
                  | (sdCtl_q.src[2] & extLow);
    end

    // restart and delay register, plain read-write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            restartDelay_q <= RESTART_DELAY_RST;
        end else if (wrAccept && avs_address == ADDR_RESTART_DELAY
                     && avs_byteenable[0]) begin
            restartDelay_q <= avs_writedata[7:0];
        end
    end

    // shutdown control; the flag is set by hardware, cleared by software
    // or by auto restart, and hardware set always beats a clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdCtl_q <= SHUTDOWN_CTRL_RST;
        end else begin
            if (flagWrite) begin
                sdCtl_q.src    <= avs_writedata[SRC_LSB+2:SRC_LSB];
                sdCtl_q.pairAc <= avs_writedata[PAIR_AC_LSB+1:PAIR_AC_LSB];
                sdCtl_q.pairBd <= avs_writedata[PAIR_BD_LSB+1:PAIR_BD_LSB];
            end
            if (condition) begin
                // flag held and writes to it ignored
                sdCtl_q.flag <= 1'b1;
            end else if (restartAuto) begin
                sdCtl_q.flag <= 1'b0;
            end else if (flagWrite) begin
                // manual mode: only software clears the flag
                sdCtl_q.flag <= avs_writedata[FLAG_BIT];
            end
        end
    end

    // output comes back only at the start of a period after the flag
    // drops; this also covers a software-raised flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            running_q <= 1'b1;
        end else if (sdCtl_q.flag) begin
            running_q <= 1'b0;
        end else if (periodStart) begin
            running_q <= 1'b1;
        end
    end

    // one edge delay per pin; a generate keeps the four lines alike
    for (genvar i = 0; i < 4; i++) begin : g_delay
        pwmsd_edge_delay #(
            .W (DELAY_W)
        ) u_delay (
            .mclk       (mclk),
            .rst        (rst),
            .rawIn      (pwmRaw[i]),
            .delayCount (delayCnt),
            .delayedOut (delayed[i])
        );
    end

    // pins: shutdown state is combinational from the flag so that it
    // applies without waiting for the next period
    always_comb begin
        logic [1:0] st;
        st = 2'b00;
        for (int i = 0; i < 4; i++) begin
            // pins a,c are 0,2; pins b,d are 1,3
            st = (i % 2 == 0) ? sdCtl_q.pairAc : sdCtl_q.pairBd;
            if (sdCtl_q.flag || !running_q) begin
                pwmPins.value[i] = (st == PAIR_HIGH);
                pwmPins.oe[i]    = ~st[1];
            end else begin
                pwmPins.value[i] = delayed[i];
                pwmPins.oe[i]    = 1'b1;
            end
        end
    end

    // enter and leave shutdown events
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            condPrev_q <= 1'b0;
        end else begin
            condPrev_q <= sdCtl_q.flag;
        end
    end
    assign irqEvent = {condPrev_q & ~sdCtl_q.flag, ~condPrev_q & sdCtl_q.flag};

    // sticky status; an event in the clearing cycle wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqStatus_q <= IRQ_RST;
        end else if (wrAccept && avs_address == ADDR_IRQ_CLEAR) begin
            irqStatus_q <= (irqStatus_q & ~avs_writedata[1:0]) | irqEvent;
        end else begin
            irqStatus_q <= irqStatus_q | irqEvent;
        end
    end

    // interrupt enable register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqEnable_q <= IRQ_RST;
        end else if (wrAccept && avs_address == ADDR_IRQ_ENABLE
                     && avs_byteenable[0]) begin
            irqEnable_q <= avs_writedata[1:0];
        end
    end
    assign irq = |(irqStatus_q & irqEnable_q);

    // read data registered at the wait-state edge, ready at the answering edge; unmapped reads zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~answered_q) begin
            case (avs_address)
                ADDR_RESTART_DELAY: avs_readdata <= {24'h0, restartDelay_q};
                ADDR_SHUTDOWN_CTRL: avs_readdata <= {24'h0, sdCtl_q};
                ADDR_IRQ_STATUS:    avs_readdata <= {30'h0, irqStatus_q};
                ADDR_IRQ_ENABLE:    avs_readdata <= {30'h0, irqEnable_q};
                default:            avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    a_flag_holds: assert property (@(posedge mclk) disable iff (rst)
        condition |=> sdCtl_q.flag)
        else $error("flag not set under condition");
    a_auto_clear: assert property (@(posedge mclk) disable iff (rst)
        !condition && restartAuto && sdCtl_q.flag |=> !sdCtl_q.flag)
        else $error("auto restart did not clear flag");
    a_manual_hold: assert property (@(posedge mclk) disable iff (rst)
        sdCtl_q.flag && !restartAuto && !flagWrite |=> sdCtl_q.flag)
        else $error("flag dropped without software");
    a_no_auto_off: assert property (@(posedge mclk) disable iff (rst)
        sdCtl_q.flag && !restartAuto && !condition && !flagWrite
        |=> sdCtl_q.flag)
        else $error("restart without enable");
    a_write_ignored: assert property (@(posedge mclk) disable iff (rst)
        flagWrite && condition |=> sdCtl_q.flag)
        else $error("flag write accepted under condition");
    sequence s_flag_drop;
        $fell(sdCtl_q.flag) ##0 !periodStart;
    endsequence
    a_wait_period: assert property (@(posedge mclk) disable iff (rst)
        s_flag_drop |=> !running_q)
        else $error("output resumed before period start");
    a_pair_state: assert property (@(posedge mclk) disable iff (rst)
        sdCtl_q.flag && sdCtl_q.pairAc == 2'b01
        |-> pwmPins.value[0] && pwmPins.oe[2])
        else $error("pair ac shutdown state wrong");
    a_src_off: assert property (@(posedge mclk) disable iff (rst)
        sdCtl_q.src == 3'b000 |-> !condition)
        else $error("disabled source raised shutdown");
    a_reset_zero: assert property (@(posedge mclk)
        $fell(rst) |-> restartDelay_q == 8'h00 && sdCtl_q == 8'h00)
        else $error("registers not zero after reset");
endmodule : pwmsd_top

//--- test/tb_pwm_shutdown_auto_restart.sv
/*
 * self-checking bench for the pwm shutdown, restart and edge delay block:
 * register table, shutdown sources, pair states, both restart modes,
 * interrupts and rising edge delay.
 * assumes the package and pwmsd_top are compiled before this file.
 */
`timescale 1ns/100ps
module tb_pwm_shutdown_auto_restart;
    import pwmsd_pkg::*;
    // one register table row: where, what is written, what reads back
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } pwmsd_row_s;
    logic              mclk, rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]        avs_address;
    logic [3:0]        avs_byteenable, pwmRaw;
    logic [31:0]       avs_writedata, avs_readdata;
    logic              periodStart, cmpOneHigh, cmpTwoHigh, extIntPin_n;
    logic              irq;       // level interrupt under test
    pwmsd_pins_s       pwmPins;   // pin values and enables
    int                badCount, comparisons, cycles;
    // upper bytes, read-only status and a hole in the map all read narrow
    pwmsd_row_s rows [5] = '{
        '{ADDR_RESTART_DELAY, 32'hffff_ffff, 32'h0000_00ff},
        '{ADDR_RESTART_DELAY, 32'h0000_0055, 32'h0000_0055},
        '{ADDR_SHUTDOWN_CTRL, 32'h0000_000f, 32'h0000_000f},
        '{ADDR_IRQ_STATUS,    32'h0000_0003, 32'h0000_0000},
        '{5'h02,              32'h0000_00ff, 32'h0000_0000}};

    pwmsd_top dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwmRaw(pwmRaw), .periodStart(periodStart), .cmpOneHigh(cmpOneHigh),
        .cmpTwoHigh(cmpTwoHigh), .extIntPin_n(extIntPin_n),
        .pwmPins(pwmPins), .irq(irq));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    // hang guard: the whole run needs far fewer cycles than this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            badCount++;
            complete_run();
        end
    end

    task complete_run;
        if (badCount == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    // pins looked at mid-cycle; value bits of a floating pair are ignored
    task automatic check_pins(input logic [7:0] exp);
        @(negedge mclk);
        check_word({24'h0, pwmPins.value & exp[3:0], pwmPins.oe},
                   {24'h0, exp[7:4] & exp[3:0], exp[3:0]});
        @(posedge mclk);
    endtask : check_pins

    // shutdown levels {value d c b a, oe d c b a} for two pair codes
    function automatic logic [7:0] sd_pins(input logic [1:0] ac,
                                           input logic [1:0] bd);
        return {bd[0], ac[0], bd[0], ac[0], ~bd[1], ~ac[1], ~bd[1], ~ac[1]};
    endfunction : sd_pins

    // request held until waitrequest is seen low at a rising edge; read
    // data is taken at that same edge, before the design updates anything
    task automatic bus_xfer(input logic wr, input logic [4:0] a,
                            input logic [31:0] d, output logic [31:0] rd);
        logic w;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
            w  = avs_waitrequest;
            rd = avs_readdata;
        end while (w !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_xfer

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_xfer(1'b0, a, 32'h0, v);
        check_word(v, exp);
    endtask : rd_chk

    // one period start strobe, then let the pins settle
    task automatic period_pulse;
        periodStart <= 1'b1;
        @(posedge mclk);
        periodStart <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : period_pulse

    // cycles from a raw line a change until pin a follows
    task automatic edge_lag(input logic lvl, output int n);
        pwmRaw <= {3'h0, lvl};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            @(negedge mclk);
        end while (pwmPins.value[0] !== lvl && n < 600);
        @(posedge mclk);
    endtask : edge_lag

    initial begin
        int          n;
        logic [2:0]  src;
        logic [1:0]  ac, bd;
        logic [7:0]  ctl;
        logic [31:0] lagExp;
        mclk = 0; rst = 1; avs_read = 0; avs_write = 0; avs_address = 5'h00;
        avs_byteenable = 4'hf; avs_writedata = 32'h0; pwmRaw = 4'h0;
        periodStart = 0; cmpOneHigh = 0; cmpTwoHigh = 0; extIntPin_n = 1;
        badCount = 0; comparisons = 0; cycles = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(ADDR_RESTART_DELAY, 32'h0);
        rd_chk(ADDR_SHUTDOWN_CTRL, 32'h0);
        check_pins(8'h0f);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        // every source code against every trigger, auto restart on
        wr(ADDR_RESTART_DELAY, 32'h80);
        for (int s = 0; s < 8; s++) begin
            for (int t = 0; t < 3; t++) begin
                src = 3'(s);
                ac  = 2'(t);
                bd  = 2'(2 - t);
                ctl = {1'b0, src, ac, bd};
                wr(ADDR_SHUTDOWN_CTRL, {24'h0, ctl});
                cmpOneHigh  <= (t == 0);
                cmpTwoHigh  <= (t == 1);
                extIntPin_n <= (t != 2);
                repeat (5) @(posedge mclk);
                rd_chk(ADDR_SHUTDOWN_CTRL, {24'h0, src[t], ctl[6:0]});
                if (src[t]) check_pins(sd_pins(ac, bd));
                cmpOneHigh  <= 1'b0;
                cmpTwoHigh  <= 1'b0;
                extIntPin_n <= 1'b1;
                repeat (5) @(posedge mclk);
                rd_chk(ADDR_SHUTDOWN_CTRL, {24'h0, ctl});
                if (src[t]) check_pins(sd_pins(ac, bd));
                period_pulse();
                check_pins(8'h0f);
            end
        end
        // manual restart with the entry interrupt enabled
        wr(ADDR_IRQ_CLEAR, 32'h3);
        rd_chk(ADDR_IRQ_STATUS, 32'h0);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        wr(ADDR_RESTART_DELAY, 32'h0);
        wr(ADDR_SHUTDOWN_CTRL, 32'h15);
        cmpOneHigh <= 1'b1;
        repeat (5) @(posedge mclk);
        check_word({31'h0, irq}, 32'h1);
        wr(ADDR_SHUTDOWN_CTRL, 32'h15);
        rd_chk(ADDR_SHUTDOWN_CTRL, 32'h95);
        cmpOneHigh <= 1'b0;
        repeat (5) @(posedge mclk);
        rd_chk(ADDR_SHUTDOWN_CTRL, 32'h95);
        check_pins(sd_pins(2'b01, 2'b01));
        wr(ADDR_IRQ_CLEAR, 32'h1);
        // the clear lands at the accepting edge; look one edge later
        @(posedge mclk);
        check_word({31'h0, irq}, 32'h0);
        wr(ADDR_SHUTDOWN_CTRL, 32'h15);
        rd_chk(ADDR_SHUTDOWN_CTRL, 32'h15);
        check_pins(sd_pins(2'b01, 2'b01));
        period_pulse();
        check_pins(8'h0f);
        rd_chk(ADDR_IRQ_STATUS, 32'h2);
        check_word({31'h0, irq}, 32'h0);
        // rising edges wait four clocks per count step, falling ones do not
        wr(ADDR_SHUTDOWN_CTRL, 32'h0);
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : ((k == 1) ? 1 : 127);
            // one register cycle plus four clocks per count step
            lagExp = (k == 0) ? 32'd1 : ((k == 1) ? 32'd5 : 32'd509);
            wr(ADDR_RESTART_DELAY, 32'(n));
            edge_lag(1'b1, n);
            check_word(32'(n), lagExp);
            edge_lag(1'b0, n);
            check_word(32'(n), 32'd1);
        end
        // a reset in mid-run clears both control registers again
        wr(ADDR_RESTART_DELAY, 32'h8f);
        wr(ADDR_SHUTDOWN_CTRL, 32'h7a);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(ADDR_RESTART_DELAY, 32'h0);
        rd_chk(ADDR_SHUTDOWN_CTRL, 32'h0);
        check_pins(8'h0f);
        complete_run();
    end
endmodule : tb_pwm_shutdown_auto_restart
